/* File: core/sbt_defs.svh */
// sbt_defs.svh: register map, field positions, reset values and timer counts
// assumes: included by bare name from the guard timer and port files of the single-bit two-wire port
`ifndef SBT_DEFS_SVH
`define SBT_DEFS_SVH

// register word addresses
`define SBT_ADDR_CTL 2'h0
`define SBT_ADDR_DAT 2'h1
`define SBT_ADDR_CFG 2'h2

// control/status write fields
`define SBT_CTL_CXA 7
`define SBT_CTL_IDLE 6
`define SBT_CTL_CDR 5
`define SBT_CTL_CLEAR_ARB_LOSS 4
`define SBT_CTL_CLEAR_START_FLAG 3
`define SBT_CTL_CLEAR_STOP_FLAG 2
`define SBT_CTL_SEND_REPEAT_START 1
`define SBT_CTL_SEND_STOP 0

// data register bit (read: receive_bit, write: transmit_bit)
`define SBT_DAT_BIT 7

// config fields
`define SBT_CFG_SLVEN 7
`define SBT_CFG_MREQ 6
`define SBT_CFG_TMO 5
`define SBT_CFG_TRUN 4
`define SBT_CFG_PSHI 1
`define SBT_CFG_PSLO 0

// reset values
`define SBT_RST_BYTE 8'h00
`define SBT_RST_IDLE 1'b1

// machine cycle length in core clocks
`define SBT_MC_DIV 6

// minimum-time counts in machine cycles, per {prescale_hi, prescale_lo}
`define SBT_MIN_PS10 4'h7
`define SBT_MIN_PS01 4'h6
`define SBT_MIN_PS00 4'h5
`define SBT_MIN_PS11 4'h4

// guard timer count at which the minimum time has elapsed
`define SBT_MIN_MARK 10'h008

`endif

/* File: core/sbt_pkg.sv */
// sbt_pkg: state types of the single-bit two-wire port
// assumes: counts and field positions come from sbt_defs.svh
package sbt_pkg;

    // start/stop generation waiting at a master
    typedef enum logic [1:0] {
        SBT_PEND_NONE,
        SBT_PEND_RSTART,
        SBT_PEND_STOP
    } sbt_pend_e;

    // whole state of the bit engine and its registers
    typedef struct packed {
        logic data_ready_flag;
        logic arb_loss_flag;
        logic str;
        logic stop_seen_flag;
        logic rbit;
        logic xact;
        logic xbit;
        logic master;
        logic idle;
        logic busy;
        logic gen_start;
        sbt_pend_e pend;
        logic sda_oe;
        logic scl_oe;
        logic pin_lvl;
        logic scl_q;
        logic sda_q;
        logic attn;
        logic tmo_pulse;
        logic tmo_seen;
        logic slv_en;
        logic mreq;
        logic trun;
        logic [1:0] ps;
        logic [7:0] rdata;
    } sbt_core_s;

    // guard timer state
    typedef struct packed {
        logic [3:0] div;
        logic [9:0] cnt;
        logic carry;
    } sbt_tmr_s;

endpackage : sbt_pkg

/* File: core/sbt_timer_if.sv */
// sbt_timer_if: wires between the bit engine and its guard timer
// assumes: both ends run on core_clk
`timescale 1ns/1ns
interface sbt_timer_if;
    logic en;
    logic full_run;
    logic in_frame;
    logic reload;
    logic [1:0] ps;
    logic min_done;
    logic carry;

    modport core (output en, output full_run, output in_frame, output reload, output ps,
                  input min_done, input carry);
    modport timer (input en, input full_run, input in_frame, input reload, input ps,
                   output min_done, output carry);
endinterface : sbt_timer_if

/* File: core/sbt_sync.sv */
// sbt_sync: two-flop synchroniser for pin levels
// assumes: inputs are asynchronous to core_clk
`timescale 1ns/1ns
module sbt_sync #(
    parameter int W = 2
) (
    // clock and reset
    input logic core_clk,
    input logic rst_n,
    // levels
    input logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sbt_sync_s;

    sbt_sync_s s;
    sbt_sync_s next_s;

    // first stage feeds only the second; idle bus is high so reset to ones
    always_comb
    begin
        next_s.s1 = d;
        next_s.s2 = s.s1;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '1;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign q = s.s2;
endmodule : sbt_sync

/* File: core/sbt_guard_timer.sv */
// sbt_guard_timer: 10-bit bus guard timer with machine-cycle divider
// assumes: reload is a one-cycle pulse from the bit engine on core_clk
`timescale 1ns/1ns
`include "sbt_defs.svh"
module sbt_guard_timer #(
    parameter int MC_DIV = `SBT_MC_DIV
) (
    // clock and reset
    input logic core_clk,
    input logic rst_n,
    // engine side
    sbt_timer_if.timer tif
);
    sbt_pkg::sbt_tmr_s s;
    sbt_pkg::sbt_tmr_s next_s;
    logic [3:0] min_cnt;
    logic [9:0] preload;
    logic tick;

    // minimum-time count selected by the prescale pair
    always_comb
    begin
        case (tif.ps)
            2'h2: min_cnt = `SBT_MIN_PS10;
            2'h1: min_cnt = `SBT_MIN_PS01;
            2'h0: min_cnt = `SBT_MIN_PS00;
            default: min_cnt = `SBT_MIN_PS11;
        endcase
    end

    assign preload = `SBT_MIN_MARK - {6'h00, min_cnt};
    assign tick = (s.div == 4'(MC_DIV - 1));

    // outside frames, or with the full run off, only the low bits count up to the mark
    always_comb
    begin
        next_s = s;
        next_s.carry = 1'b0;
        if (!tif.en)
        begin
            next_s.div = 4'h0;
            next_s.cnt = 10'h000;
        end
        else
        begin
            next_s.div = tick ? 4'h0 : s.div + 4'h1;
            if (tif.reload)
            begin
                next_s.cnt = preload;
            end
            else if (tick && tif.full_run && tif.in_frame)
            begin
                {next_s.carry, next_s.cnt} = {1'b0, s.cnt} + 11'h001;
            end
            else if (tick && (s.cnt[9:3] == 7'h00))
            begin
                next_s.cnt = s.cnt + 10'h001;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
        end
        else
        begin
            s <= next_s;
        end
    end

    assign tif.min_done = (s.cnt[9:3] != 7'h00);
    assign tif.carry = s.carry;

    a_timer_disabled: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        !tif.en |=> (s.cnt == 10'h000) && !s.carry)
        else $error("guard timer runs while the port is disabled");

    a_low_bits_only: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        tif.en && !tif.full_run && (s.cnt <= 10'h008) |=> (s.cnt <= 10'h008) && !s.carry)
        else $error("guard timer passed the mark without full run");

    a_preload_mark: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        tif.en && tif.reload && (tif.ps == 2'h2) |=> (s.cnt == 10'h001))
        else $error("guard timer preload wrong for prescale 1 0");
endmodule : sbt_guard_timer

/* File: core/sbt_port.sv */
// sbt_port: single-bit two-wire port with flags, arbitration and clock stretching
// assumes: plain register port on core_clk; pins are open-drain, wired outside
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "sbt_defs.svh"
module sbt_port #(
    parameter int MC_DIV = `SBT_MC_DIV
) (
    // clock and reset
    input logic core_clk,
    input logic rst_n,
    // register port
    input logic [1:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    output logic [7:0] reg_rdata,
    // two-wire pins
    input logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    // status
    output logic attention,
    output logic guard_timeout
);
    sbt_pkg::sbt_core_s s;
    sbt_pkg::sbt_core_s next_s;
    sbt_timer_if tif ();
    logic [1:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic enabled;
    logic idle_slave;
    logic attn_any;
    logic wr_ctl;
    logic wr_dat;
    logic wr_cfg;
    logic rd_dat;
    logic set_data_ready_flag;
    logic set_arl;
    logic set_str;
    logic set_stp;
    logic acquire;
    logic clr_data_ready_flag;
    logic clr_xact;
    logic set_xact;

    // pins pass two flops before anything looks at them
    sbt_sync #(.W(2)) u_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .d({scl_in, sda_in}),
        .q(pins_s)
    );

    sbt_guard_timer #(.MC_DIV(MC_DIV)) u_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .tif(tif)
    );

    // bus events from the synchronised levels
    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];
    assign scl_rise = scl_s && !s.scl_q;
    assign scl_fall = !scl_s && s.scl_q;
    assign start_cond = scl_s && s.scl_q && s.sda_q && !sda_s;
    assign stop_cond = scl_s && s.scl_q && !s.sda_q && sda_s;
    assign enabled = s.slv_en || s.mreq || s.master;
    assign idle_slave = !s.master && s.idle;
    assign attn_any = s.data_ready_flag || s.arb_loss_flag || s.str || s.stop_seen_flag;

    // register strobes
    assign wr_ctl = reg_wr && (reg_addr == `SBT_ADDR_CTL);
    assign wr_dat = reg_wr && (reg_addr == `SBT_ADDR_DAT);
    assign wr_cfg = reg_wr && (reg_addr == `SBT_ADDR_CFG);
    assign rd_dat = reg_rd && (reg_addr == `SBT_ADDR_DAT);

    // timer hookup
    assign tif.en = enabled;
    assign tif.full_run = s.trun;
    assign tif.in_frame = s.busy;
    assign tif.reload = enabled && (scl_rise || scl_fall || start_cond || stop_cond);
    assign tif.ps = s.ps;

    // flag set terms; a loss needs transmit active; own starts flag too so software sends bit one
    assign set_data_ready_flag = enabled && scl_rise && !idle_slave;
    assign set_arl = enabled && s.xact && (
        (scl_rise && s.xbit && !sda_s) ||
        (start_cond && s.xbit && !s.sda_oe && !s.gen_start) ||
        (s.master && (s.pend == sbt_pkg::SBT_PEND_RSTART) && scl_fall) ||
        (s.master && (s.pend == sbt_pkg::SBT_PEND_STOP) && scl_fall));
    assign set_str = enabled && start_cond && !idle_slave;
    assign set_stp = enabled && stop_cond && !idle_slave;
    assign acquire = enabled && s.mreq && !s.master && !s.busy && tif.min_done &&
                     scl_s && sda_s && !tif.carry;

    // clear and set terms of the software-visible state
    assign clr_data_ready_flag = (wr_ctl && reg_wdata[`SBT_CTL_CDR]) || wr_dat || rd_dat;
    assign clr_xact = (wr_ctl && reg_wdata[`SBT_CTL_CXA]) || rd_dat;
    assign set_xact = wr_dat ||
                      (wr_ctl && (reg_wdata[`SBT_CTL_SEND_REPEAT_START] || reg_wdata[`SBT_CTL_SEND_STOP]));

    // next state; a flag set in the cycle of its clear survives
    always_comb
    begin
        next_s = s;
        next_s.scl_q = scl_s;
        next_s.sda_q = sda_s;
        next_s.tmo_pulse = 1'b0;
        next_s.rdata = `SBT_RST_BYTE;
        // read data stand for the one cycle after the strobe
        if (reg_rd)
        begin
            case (reg_addr)
                `SBT_ADDR_CTL: next_s.rdata = {s.rbit, attn_any, s.data_ready_flag, s.arb_loss_flag, s.str, s.stop_seen_flag,
                                               s.master, 1'b0};
                `SBT_ADDR_DAT: next_s.rdata = {s.rbit, 7'h00};
                `SBT_ADDR_CFG: next_s.rdata = {s.slv_en, s.mreq, s.tmo_seen, s.trun, 2'h0,
                                               s.ps};
                default: next_s.rdata = `SBT_RST_BYTE;
            endcase
        end
        // configuration
        if (wr_cfg)
        begin
            next_s.slv_en = reg_wdata[`SBT_CFG_SLVEN];
            next_s.mreq = reg_wdata[`SBT_CFG_MREQ];
            next_s.trun = reg_wdata[`SBT_CFG_TRUN];
            next_s.ps = {reg_wdata[`SBT_CFG_PSHI], reg_wdata[`SBT_CFG_PSLO]};
        end
        next_s.tmo_seen = (s.tmo_seen && !(wr_cfg && reg_wdata[`SBT_CFG_TMO])) || tif.carry;
        // flags
        if (set_data_ready_flag)
        begin
            next_s.rbit = sda_s;
        end
        next_s.data_ready_flag = (s.data_ready_flag && !clr_data_ready_flag) || set_data_ready_flag;
        next_s.arb_loss_flag = (s.arb_loss_flag && !(wr_ctl && reg_wdata[`SBT_CTL_CLEAR_ARB_LOSS])) || set_arl;
        next_s.str = (s.str && !(wr_ctl && reg_wdata[`SBT_CTL_CLEAR_START_FLAG])) || set_str;
        next_s.stop_seen_flag = (s.stop_seen_flag && !(wr_ctl && reg_wdata[`SBT_CTL_CLEAR_STOP_FLAG])) || set_stp;
        // transmit bit and pending start/stop; stop wins if both are asked
        if (wr_dat)
        begin
            next_s.xbit = reg_wdata[`SBT_DAT_BIT];
        end
        if (wr_ctl && reg_wdata[`SBT_CTL_SEND_REPEAT_START])
        begin
            next_s.xbit = 1'b1;
            next_s.pend = sbt_pkg::SBT_PEND_RSTART;
        end
        if (wr_ctl && reg_wdata[`SBT_CTL_SEND_STOP])
        begin
            next_s.xbit = 1'b0;
            next_s.pend = sbt_pkg::SBT_PEND_STOP;
        end
        // idle slave wakes only on a start
        if (wr_ctl && reg_wdata[`SBT_CTL_IDLE])
        begin
            next_s.idle = 1'b1;
        end
        else if (start_cond)
        begin
            next_s.idle = 1'b0;
        end
        // bus busy between start and stop
        if (start_cond)
        begin
            next_s.busy = 1'b1;
        end
        else if (stop_cond)
        begin
            next_s.busy = 1'b0;
        end
        if (scl_fall || stop_cond)
        begin
            next_s.gen_start = 1'b0;
        end
        // a stop seen while master with the request withdrawn ends mastership
        if (stop_cond && s.master && !s.mreq)
        begin
            next_s.master = 1'b0;
        end
        // SDA: written bit reaches the pin only during SCL low
        if (!scl_s)
        begin
            next_s.sda_oe = s.xact && !s.xbit;
        end
        // free bus with request: take it with an automatic start
        if (acquire)
        begin
            next_s.master = 1'b1;
            next_s.xact = 1'b1;
            next_s.xbit = 1'b0;
            next_s.sda_oe = 1'b1;
            next_s.gen_start = 1'b1;
        end
        else
        begin
            next_s.xact = (s.xact && !clr_xact) || set_xact;
        end
        // repeated start and stop wait the minimum time after SCL rose
        if (s.master && scl_s && s.scl_q && tif.min_done)
        begin
            if (s.pend == sbt_pkg::SBT_PEND_RSTART)
            begin
                next_s.sda_oe = 1'b1;
                next_s.gen_start = 1'b1;
                next_s.pend = sbt_pkg::SBT_PEND_NONE;
            end
            else if ((s.pend == sbt_pkg::SBT_PEND_STOP) && s.sda_oe)
            begin
                next_s.sda_oe = 1'b0;
                next_s.busy = 1'b0; // frame ends here, so the master does not clock SCL low again
                next_s.pend = sbt_pkg::SBT_PEND_NONE;
            end
        end
        // losing arbitration drops transmit, mastership and any pending request
        if (set_arl || s.arb_loss_flag)
        begin
            next_s.xact = 1'b0;
            next_s.pend = sbt_pkg::SBT_PEND_NONE;
            next_s.gen_start = 1'b0;
        end
        if (set_arl)
        begin
            next_s.master = 1'b0;
        end
        if (!next_s.xact)
        begin
            next_s.sda_oe = 1'b0;
        end
        // SCL: stretch while flags stand, master clocks after the minimum high time
        if (!enabled)
        begin
            next_s.scl_oe = 1'b0;
        end
        else if (!scl_s && attn_any)
        begin
            next_s.scl_oe = 1'b1;
        end
        else if (s.scl_oe && (attn_any || (s.master && !tif.min_done)))
        begin
            next_s.scl_oe = 1'b1;
        end
        else if (s.master && s.busy && scl_s && s.scl_q && tif.min_done &&
                 (s.pend == sbt_pkg::SBT_PEND_NONE))
        begin
            next_s.scl_oe = 1'b1;
        end
        else
        begin
            next_s.scl_oe = 1'b0;
        end
        if (!enabled)
        begin
            next_s.sda_oe = 1'b0;
        end
        // hung bus: the carry resets the engine and lets the others go on
        if (tif.carry)
        begin
            next_s.data_ready_flag = 1'b0;
            next_s.arb_loss_flag = 1'b0;
            next_s.str = 1'b0;
            next_s.stop_seen_flag = 1'b0;
            next_s.xact = 1'b0;
            next_s.master = 1'b0;
            next_s.busy = 1'b0;
            next_s.idle = `SBT_RST_IDLE;
            next_s.gen_start = 1'b0;
            next_s.pend = sbt_pkg::SBT_PEND_NONE;
            next_s.sda_oe = 1'b0;
            next_s.scl_oe = 1'b0;
            next_s.tmo_pulse = 1'b1;
        end
        next_s.attn = next_s.data_ready_flag || next_s.arb_loss_flag || next_s.str || next_s.stop_seen_flag;
    end

    // one register for all state; idle slave after reset
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
            s.idle <= `SBT_RST_IDLE;
            s.scl_q <= 1'b1;
            s.sda_q <= 1'b1;
        end
        else
        begin
            s <= next_s;
        end
    end

    // outputs straight from the state register
    assign reg_rdata = s.rdata;
    assign sda_out = s.pin_lvl;
    assign sda_oe = s.sda_oe;
    assign scl_out = s.pin_lvl;
    assign scl_oe = s.scl_oe;
    assign attention = s.attn;
    assign guard_timeout = s.tmo_pulse;

    a_stretch_hold: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        enabled && !scl_s && attn_any && !tif.carry |=> s.scl_oe)
        else $error("SCL released while a flag stands");

    a_clear_keeps_low: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        enabled && s.scl_oe && !scl_s && (s.arb_loss_flag || s.str || s.stop_seen_flag) && !tif.carry
        |=> s.scl_oe)
        else $error("SCL released with loss, start or stop flag set");

    a_arl_kills_xact: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s.arb_loss_flag |-> !s.xact)
        else $error("transmit active with arbitration loss set");

    a_sda_needs_xact: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        s.sda_oe |-> s.xact && !s.arb_loss_flag)
        else $error("SDA driven without transmit active");

    a_loss_drops_master: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        $rose(s.arb_loss_flag) |-> !s.master)
        else $error("still master after arbitration loss");

    a_rise_sets_ready: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        set_data_ready_flag && !tif.carry |=> s.data_ready_flag && (s.rbit == $past(sda_s)))
        else $error("SCL rise did not capture SDA");

    a_clear_arl: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wr_ctl && reg_wdata[`SBT_CTL_CLEAR_ARB_LOSS] && !set_arl |=> !s.arb_loss_flag)
        else $error("arbitration loss not cleared");

    a_write_sets_xact: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        wr_dat && !s.arb_loss_flag && !set_arl && !tif.carry |=> s.xact)
        else $error("data write did not set transmit active");

    a_idle_no_start: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        start_cond && idle_slave && !s.str |=> !s.str)
        else $error("start flag set at an idle slave");

    a_timeout_reset: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        tif.carry |=> !s.scl_oe && !s.master && !s.attn && s.tmo_pulse)
        else $error("timer carry did not reset the port");
endmodule : sbt_port

/* File: verification/sbt_far_master.sv */
// sbt_far_master: another master on the two-wire bus, clocking bits at a 240 ns period (160 ns low, 80 ns high)
// assumes: the bench wires SDA and SCL as pulled-up open-drain lines from both parties
`timescale 1ns/1ns
module sbt_far_master (
    // wire levels
    input wire logic scl,
    input wire logic sda,
    // pull-downs of this party
    output logic scl_pull,
    output logic sda_pull
);
    localparam int HALF = 80;

    // released lines fall back to the pull-up level
    initial
    begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
    end

    // bounded wait: the port may stretch SCL low for as long as software takes
    task automatic wait_high();
        int n;
        for (n = 0; n < 4000 && scl !== 1'b1; n++)
            #8;
    endtask : wait_high

    // SDA falls while SCL is high, then SCL goes low
    task automatic start_cond();
        sda_pull = 1'b1;
        #HALF;
        scl_pull = 1'b1;
        #HALF;
    endtask : start_cond

    // data changes only in the low phase, then one full clock pulse
    task automatic send_bit(input logic b);
        sda_pull = !b;
        #HALF;
        scl_pull = 1'b0;
        wait_high();
        #HALF;
        scl_pull = 1'b1;
        #HALF;
    endtask : send_bit

    // SDA rises while SCL is high
    task automatic stop_cond();
        sda_pull = 1'b1;
        #HALF;
        scl_pull = 1'b0;
        wait_high();
        #HALF;
        sda_pull = 1'b0;
        #HALF;
    endtask : stop_cond
endmodule : sbt_far_master

/* File: verification/tb_sbt_port.sv */
// tb_sbt_port: register-level bench of the single-bit two-wire port as a slave, then as a master
// assumes: a far master clocks the bus; MC_DIV is 1 to keep minimum times short
`timescale 1ns/1ns
module tb_sbt_port;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic sda_out;
    logic sda_oe;
    logic scl_out;
    logic scl_oe;
    logic attention;
    logic guard_timeout;
    logic scl_pull;
    logic sda_pull;
    wire scl_wire = !(scl_oe | scl_pull);
    wire sda_wire = !(sda_oe | sda_pull);
    int failures = 0;
    int checked = 0;
    int waited = 0;

    // 125 MHz core clock
    always #4 core_clk = ~core_clk;

    sbt_port #(.MC_DIV(1)) uut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .scl_in(scl_wire),
        .scl_out(scl_out), .scl_oe(scl_oe), .attention(attention),
        .guard_timeout(guard_timeout));

    sbt_far_master far (.scl(scl_wire), .sda(sda_wire), .scl_pull(scl_pull),
        .sda_pull(sda_pull));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // one-cycle write strobe
    task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : reg_write

    // read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [1:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask : reg_read

    task automatic settle(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : settle

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : print_verdict

    // watchdog well beyond the roughly ten microseconds the sequence needs, most of it the guard timer wait
    initial
    begin
        #300000;
        failures++;
        print_verdict();
    end

    initial
    begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
        reg_read(2'h0, 8'h00);
        reg_read(2'h2, 8'h00);
        reg_read(2'h3, 8'h00);
        reg_write(2'h2, 8'h80);
        reg_read(2'h2, 8'h80);
        // idle slave woken by a start, first bit a one
        far.start_cond();
        far.send_bit(1'b1);
        settle(8);
        check(scl_oe, 8'h01);
        check(attention, 8'h01);
        reg_read(2'h0, 8'hE0);
        // answer with a zero; SDA only moves in the low phase
        reg_write(2'h1, 8'h00);
        settle(4);
        check(sda_oe, 8'h01);
        check(scl_oe, 8'h00);
        far.send_bit(1'b1);
        settle(8);
        reg_read(2'h0, 8'h60);
        reg_read(2'h1, 8'h00);
        settle(4);
        check(sda_oe, 8'h00);
        check(scl_oe, 8'h00);
        // send a one while the far side drives zero
        reg_write(2'h1, 8'h80);
        far.send_bit(1'b0);
        settle(8);
        reg_read(2'h0, 8'h70);
        reg_write(2'h0, 8'h20);
        settle(4);
        check(scl_oe, 8'h01);
        check(sda_oe, 8'h00);
        reg_write(2'h0, 8'h10);
        settle(4);
        check(scl_oe, 8'h00);
        // stop at a busy slave
        far.stop_cond();
        settle(8);
        reg_read(2'h0, 8'h64);
        reg_write(2'h0, 8'h24);
        settle(4);
        check(attention, 8'h00);
        check({6'h00, sda_out, scl_out}, 8'h00);
        // hung frame: a start, then SCL held low until the guard timer carries
        reg_write(2'h2, 8'h92);
        far.start_cond();
        reg_read(2'h0, 8'h48);
        for (waited = 0; waited < 1200 && guard_timeout !== 1'b1; waited++)
            @(negedge core_clk);
        check(guard_timeout, 8'h01);
        check(8'(waited >= 1000 && waited < 1030), 8'h01);
        reg_read(2'h2, 8'hB2);
        check(scl_oe, 8'h00);
        // a stop at the idle slave with the request set hands it the bus
        reg_write(2'h2, 8'hD2);
        far.stop_cond();
        settle(40);
        reg_read(2'h0, 8'h4A);
        check({6'h00, sda_oe, scl_oe}, 8'h03);
        // withdraw the request, then send the stop
        reg_write(2'h2, 8'h92);
        reg_write(2'h0, 8'h29);
        settle(40);
        reg_read(2'h0, 8'h64);
        check({6'h00, sda_oe, scl_oe}, 8'h00);
        print_verdict();
    end
endmodule : tb_sbt_port
